// ### iso_params.svh
`ifndef ISO_PARAMS_SVH
`define ISO_PARAMS_SVH
// register byte offsets
`define ISO_REG_CTRL      12'h000
`define ISO_REG_STAT      12'h004
`define ISO_REG_FRAME     12'h008
`define ISO_REG_CNT_BASE  12'h010
// control word fields: mask in low byte, frame number bits 15..11 of descriptor dword
`define ISO_MASK_LSB      0
`define ISO_MASK_MSB      7
`define ISO_FRM_LSB       11
`define ISO_FRM_MSB       15
`define ISO_DIR_BIT       16
// status word fields
`define ISO_RES_LSB       8
`define ISO_RES_W         3
`define ISO_ERR_BIT       0
`define ISO_BAB_BIT       1
`define ISO_UND_BIT       2
// reset values
`define ISO_ZERO32        32'h0000_0000
`define ISO_ZERO8         8'h00
`define ISO_ZERO12        12'h000
`endif

// ### iso_pkg.sv
package iso_pkg;
    typedef enum logic [2:0] {
        ISO_IDLE = 3'b001,
        ISO_WAIT = 3'b010,
        ISO_DONE = 3'b100
    } iso_state_t;
    typedef enum logic {
        ISO_DIR_OUT = 1'b0,
        ISO_DIR_IN  = 1'b1
    } iso_dir_t;
endpackage

// ### iso_sched.sv
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "iso_params.svh"
////////////////////////////////////////////////////////////////////////////////
// register map, one aligned 32-bit word each:
//   ctrl  : [7:0] active mask (a write ors bits in, software can never clear one),
//           [15:11] frame number the descriptor belongs to, [16] token, 1 = in
//   stat  : [31:8] eight 3-bit results, microframe 7 on top, [7:0] live mask
//   frame : [4:0] bus frame number as seen right now, read only
//   count : one word per microframe, 12-bit received byte count, in token only
// writes to read-only words are dropped; unmapped words answer with pslverr
//
// timing as seen from the bus:
//   writes complete with no wait state
//   reads take one wait state so that the answer comes from a flip-flop
//   and still stands at the edge where the master samples pready high
//
// timing as seen from the transfer engine:
//   uframe_start at edge n, iso_issue high after it while the engine works
//   xact_done at edge m, result, count and mask clear visible after it
//   one idle cycle in the done state follows, so a new issue needs two cycles
//
// limitation: one descriptor only; the token is taken from the live control
// word, so software must not flip it while a transaction is outstanding
////////////////////////////////////////////////////////////////////////////////
module iso_sched
    import iso_pkg::*;
#(
    parameter int NUM_UF = 8,
    parameter int CNT_W  = 12
) (
    input  wire logic          ref_clk,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          uframe_start,
    input  wire logic [2:0]    uframe_index,
    input  wire logic [4:0]    bus_frame_number,
    output logic               iso_issue,
    output logic [2:0]         iso_issue_uframe,
    output logic               iso_issue_in,
    input  wire logic          xact_done,
    input  wire logic          xact_error,
    input  wire logic          xact_babble,
    input  wire logic          xact_underrun,
    input  wire logic [11:0]   xact_rx_bytes
);
    initial begin
        if (NUM_UF != 8 || CNT_W != 12)
            $error("iso_sched supports eight microframes of 12-bit counts only");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]                 microframe_active_mask_q;
    logic [4:0]                 frame_q;
    iso_dir_t                   dir_q;
    logic [23:0]                result_q;
    logic [CNT_W-1:0]           cnt_q [NUM_UF];
    iso_state_t                 st_q;
    logic [2:0]                 cur_q;
    logic [31:0]                prdata_q;
    logic                       rd_wait_q;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; writes have no wait state, unmapped addresses answer with pslverr
    wire         wr_acc   = psel && penable && pwrite;
    wire         rd_acc   = psel && penable && !pwrite;
    wire         hit_ctrl = (paddr == `ISO_REG_CTRL);
    wire         hit_stat = (paddr == `ISO_REG_STAT);
    wire         hit_frm  = (paddr == `ISO_REG_FRAME);
    wire [11:0]  cnt_off  = paddr - `ISO_REG_CNT_BASE;
    wire         hit_cnt  = (paddr >= `ISO_REG_CNT_BASE) && (cnt_off[11:2] < 10'(NUM_UF))
                            && (paddr[1:0] == 2'b00);
    wire [2:0]   cnt_sel  = cnt_off[4:2];
    wire         mapped   = hit_ctrl || hit_stat || hit_frm || hit_cnt;
    // a read holds pready low for its first access cycle; the mux is captured
    // then, so the registered answer is already standing when pready rises
    wire         rd_first = rd_acc && !rd_wait_q;
    assign pready  = !rd_acc || rd_wait_q;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_q;

    wire [31:0] ctrl_view = {15'h0000, dir_q, frame_q, 3'b000, microframe_active_mask_q};
    wire [31:0] stat_view = {result_q, microframe_active_mask_q};
    wire [31:0] rd_mux    = hit_ctrl ? ctrl_view :
                            hit_stat ? stat_view :
                            hit_frm  ? {27'h000_0000, bus_frame_number} :
                            hit_cnt  ? {20'h0_0000, cnt_q[cnt_sel]} : `ISO_ZERO32;

    ////////////////////////////////////////////////////////////////////////////
    // scheduling decisions
    // the descriptor is only looked at when its frame number matches the bus,
    // and then only for microframes whose mask bit is still set; a start pulse
    // seen while a transaction is outstanding is dropped, which is safe since
    // the engine cannot run two transactions of one descriptor at once
    wire frame_match = (frame_q == bus_frame_number);
    wire uf_enabled  = microframe_active_mask_q[uframe_index];
    wire do_issue    = (st_q == ISO_IDLE) && uframe_start && frame_match && uf_enabled;
    wire done_now    = (st_q == ISO_WAIT) && xact_done;
    // token-qualified flags: babble is meaningless on OUT, underrun on IN
    wire [2:0] res_new;
    assign res_new[`ISO_ERR_BIT] = xact_error;
    assign res_new[`ISO_BAB_BIT] = xact_babble && (dir_q == ISO_DIR_IN);
    assign res_new[`ISO_UND_BIT] = xact_underrun && (dir_q == ISO_DIR_OUT);
    wire [7:0] sw_set = (wr_acc && hit_ctrl) ? pwdata[`ISO_MASK_MSB:`ISO_MASK_LSB] : `ISO_ZERO8;

    assign iso_issue        = (st_q == ISO_WAIT);
    assign iso_issue_uframe = cur_q;
    assign iso_issue_in     = (dir_q == ISO_DIR_IN);

    ////////////////////////////////////////////////////////////////////////////
    // state machine: idle -> wait for transaction -> done (one cycle)
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q  <= ISO_IDLE;
            cur_q <= 3'b000;
        end else begin
            case (st_q)
                ISO_IDLE: if (do_issue) begin
                    st_q  <= ISO_WAIT;
                    cur_q <= uframe_index;
                end
                ISO_WAIT: if (xact_done) st_q <= ISO_DONE;
                ISO_DONE: st_q <= ISO_IDLE;
                default:  st_q <= ISO_IDLE;
            endcase
        end
    end

    // control and mask; a software set in the done cycle wins over the clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            microframe_active_mask_q <= `ISO_ZERO8;
            frame_q                  <= 5'b00000;
            dir_q                    <= ISO_DIR_OUT;
        end else begin
            microframe_active_mask_q <= (microframe_active_mask_q
                & ~(done_now ? (8'h01 << cur_q) : `ISO_ZERO8)) | sw_set;
            if (wr_acc && hit_ctrl) begin
                frame_q <= pwdata[`ISO_FRM_MSB:`ISO_FRM_LSB];
                dir_q   <= iso_dir_t'(pwdata[`ISO_DIR_BIT]);
            end
        end
    end

    // per-microframe result fields and rx counts
    // each field is written only when its own transaction completes, so the
    // results of earlier microframes survive while later ones run; counts are
    // left alone on out transfers because no bytes come back then
    genvar g;
    generate
        for (g = 0; g < NUM_UF; g++) begin : g_uf
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    result_q[g*`ISO_RES_W +: `ISO_RES_W] <= 3'b000;
                    cnt_q[g]                             <= `ISO_ZERO12;
                end else if (done_now && cur_q == 3'(g)) begin
                    result_q[g*`ISO_RES_W +: `ISO_RES_W] <= res_new;
                    if (dir_q == ISO_DIR_IN)
                        cnt_q[g] <= xact_rx_bytes;
                end
            end
        end
    endgenerate

    // read wait state: set for exactly one cycle per read access
    always_ff @(posedge ref_clk) begin
        if (rst) rd_wait_q <= 1'b0;
        else rd_wait_q <= rd_first;
    end

    // read data captured in the first access cycle, stands in the second
    always_ff @(posedge ref_clk) begin
        if (rst) prdata_q <= `ISO_ZERO32;
        else if (rd_first) prdata_q <= rd_mux;
    end
endmodule

// ### iso_sched_properties.sv
`timescale 1ns/1ps
module iso_sched_properties (
    input wire logic        ref_clk, rst, psel, penable, pwrite, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        uframe_start, iso_issue, iso_issue_in, xact_done,
    input wire logic [2:0]  uframe_index, iso_issue_uframe,
    input wire logic [4:0]  bus_frame_number
);
    logic [7:0] m_q;
    logic [5:0] c_q;
    logic       wr;
    logic [7:0] clr;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // shadow mask: the clear lands first so a same-cycle set wins
    assign wr  = psel && penable && pwrite && paddr == 12'h000;
    assign clr = 8'(iso_issue && xact_done) << iso_issue_uframe;
    always_ff @(posedge ref_clk) begin
        m_q <= rst ? 8'h00 : (m_q & ~clr) | (wr ? pwdata[7:0] : 8'h00);
        c_q <= rst ? 6'h00 : (wr ? pwdata[16:11] : c_q);
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_go; $rose(iso_issue) |-> $past(uframe_start); endproperty
    a_go: assert property (p_go) else $error("issue without start");
    property p_uf; $rose(iso_issue) |-> iso_issue_uframe == $past(uframe_index); endproperty
    a_uf: assert property (p_uf) else $error("wrong microframe");
    property p_fr; $rose(iso_issue) |-> $past(bus_frame_number) == $past(c_q[4:0]); endproperty
    a_fr: assert property (p_fr) else $error("frame mismatch");
    property p_mk; $rose(iso_issue) |-> $past(m_q[uframe_index]); endproperty
    a_mk: assert property (p_mk) else $error("mask bit clear");
    property p_dr; $rose(iso_issue) |-> iso_issue_in == $past(c_q[5]); endproperty
    a_dr: assert property (p_dr) else $error("wrong token");
    property p_hd; iso_issue && !xact_done |=> iso_issue; endproperty
    a_hd: assert property (p_hd) else $error("issue dropped");
    property p_en; iso_issue && xact_done |=> !iso_issue [*2]; endproperty
    a_en: assert property (p_en) else $error("issue held");
    property p_se; psel && penable && paddr == 12'h00c |-> pslverr; endproperty
    a_se: assert property (p_se) else $error("no slave error");
endmodule
bind iso_sched iso_sched_properties CHK (.ref_clk, .rst, .psel, .penable, .pwrite, .pslverr,
    .paddr, .pwdata, .uframe_start, .iso_issue, .iso_issue_in, .xact_done, .uframe_index,
    .iso_issue_uframe, .bus_frame_number);

// ### iso_engine_model.sv
`timescale 1ns/1ps
module iso_engine_model (
    input  wire logic        ref_clk, rst, iso_issue,
    input  wire logic [2:0]  flags,
    input  wire logic [11:0] bytes,
    output logic             xact_done, xact_error, xact_babble, xact_underrun,
    output logic [11:0]      xact_rx_bytes
);
    logic [2:0] n_q;
    // one done pulse three cycles into each issue; data scrambled outside it
    always_ff @(posedge ref_clk) begin
        n_q       <= (rst || !iso_issue || xact_done) ? 3'd0 : n_q + 3'd1;
        xact_done <= !rst && iso_issue && !xact_done && n_q == 3'd2;
    end
    assign {xact_underrun, xact_babble, xact_error} = xact_done ? flags : ~flags;
    assign xact_rx_bytes = xact_done ? bytes : ~bytes;
endmodule

// ### iso_sched_tb.sv
`timescale 1ns/1ps
module iso_sched_tb;
    logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, uframe_start = 0;
    logic        pslverr, pready, iso_issue, iso_issue_in, er;
    logic        xact_done, xact_error, xact_babble, xact_underrun;
    logic [11:0] paddr = 0, bytes = 0, xact_rx_bytes;
    logic [31:0] pwdata = 0, prdata, rd, ex;
    logic [2:0]  uframe_index = 0, iso_issue_uframe, flags = 0;
    logic [4:0]  bus_frame_number = 0;
    int          errors = 0, num_checks = 0, cyc = 0;
    iso_sched DUT (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .uframe_start, .uframe_index, .bus_frame_number, .iso_issue, .iso_issue_uframe,
        .iso_issue_in, .xact_done, .xact_error, .xact_babble, .xact_underrun, .xact_rx_bytes);
    iso_engine_model ENG (.ref_clk, .rst, .iso_issue, .flags, .bytes, .xact_done, .xact_error,
        .xact_babble, .xact_underrun, .xact_rx_bytes);
    always #10 ref_clk = ~ref_clk;
    // hang guard, far above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read data and error are taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        er = pslverr;
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic uf(input logic [2:0] i, input logic exp);
        @(posedge ref_clk);
        {uframe_start, uframe_index} <= {1'b1, i};
        @(posedge ref_clk);
        uframe_start <= 0;
        @(negedge ref_clk);
        chk(iso_issue, exp);
        repeat (8) @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_in();
        apb(1, 12'h000, 32'h0001_5055);
        bus_frame_number <= 5'h0a;
        ex = 32'h0000_0000;
        for (int i = 0; i < 8; i++) begin
            flags <= 3'b111;
            bytes <= 12'h100 + 12'(i);
            uf(3'(i), !i[0]);
            if (!i[0]) ex |= 32'h0000_0300 << (3 * i);
        end
        apb(0, 12'h004, 0);
        chk(rd, ex);
        for (int i = 0; i < 8; i++) begin
            apb(0, 12'h010 + 12'(4 * i), 0);
            chk(rd, i[0] ? 32'h0 : 32'h100 + 32'(i));
        end
    endtask
    // out token, wrong frame first, then an attempt to clear the mask
    task automatic t_out();
        apb(1, 12'h000, 32'h0000_5001);
        bus_frame_number <= 5'h0b;
        uf(0, 0);
        apb(1, 12'h000, 32'h0000_5000);
        apb(0, 12'h004, 0);
        chk(rd, ex | 32'h0000_0001);
        bus_frame_number <= 5'h0a;
        uf(0, 1);
        apb(0, 12'h004, 0);
        chk(rd, ex & 32'hffff_f8ff | 32'h0000_0500);
        apb(0, 12'h00c, 0);
        chk(er, 1);
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 0;
        apb(0, 12'h004, 0);
        chk(rd, 32'h0000_0000);
        t_in();
        t_out();
        tally_and_finish();
    end
endmodule
